// [rtl/link_cfg_regs.sv]
`timescale 1ns/1ps
// Function
// - Insert flagged control bytes only when enabled
// - Self-sync test lets slave sync alone
// - Role bit: zero master, one slave
// - Role and rate reset to build settings
// - Transmit only while enable bit set
// - Rate field chooses next sync rate
// - Non-zero negotiated rate overrides field
// - Rate field writable only with negotiation
// - Valid flag for received version byte
// - Received version shown read-only, resets zero
// - Version auto-negotiation enable bit
// - Auto and filter bits depend on build
// - Filter accepts version after five hyperframes
// - Transmit version one plain, two scrambled
// - Auto-negotiation updates transmit version itself
// - Zero scrambler seed means no scrambling
module link_cfg_regs
  import link_cfg_pkg::*;
#(
  parameter logic ROLE_AT_BUILD = ROLE_MASTER,
  parameter logic [RATE_W-1:0] RATE_AT_BUILD = RATE_DEFAULT,
  parameter bit RATE_NEGO_EN = 1'b1,
  parameter bit VER_NEGO_EN = 1'b1
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire link_cfg_pkg::reg_req_s req,
  output logic [31:0] rdata,
  input wire logic seed_zero,
  input wire link_cfg_pkg::link_stat_s stat,
  input wire logic [1:0] ins_flag,
  output logic [1:0] ins_strobe,
  output link_cfg_pkg::link_ctrl_s ctrl
);
  import link_cfg_pkg::*;

  default clocking check_cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [RATE_W-1:0] rate_r, rate_nxt;
  logic auto_r, auto_nxt;
  logic filt_r, filt_nxt;
  logic [7:0] txver_r, txver_nxt;
  logic [7:0] rxver_r, rxver_nxt;
  logic [7:0] cand_r, cand_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [31:0] rdata_nxt;
  link_ctrl_s ctrl_nxt_s;
  logic [1:0] ins_nxt;
  logic rx_valid;

  assign rx_valid = (rxver_r == VER_PLAIN) || (rxver_r == VER_SCRAMBLED);

  // ----------------------------------------------------------------------
  // Register writes and version tracking
  // ----------------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    rate_nxt = rate_r;
    auto_nxt = auto_r;
    filt_nxt = filt_r;
    txver_nxt = txver_r;
    rxver_nxt = rxver_r;
    cand_nxt = cand_r;
    cnt_nxt = cnt_r;
    if (req.wr && req.addr == OFS_CTRL)
    begin
      ctrl_nxt = req.wdata[3:0];
    end
    if (req.wr && req.addr == OFS_RATE && RATE_NEGO_EN)
    begin
      rate_nxt = req.wdata[RATE_W-1:0];
    end
    if (req.wr && req.addr == OFS_VER)
    begin
      txver_nxt = req.wdata[VER_TX_LSB +: 8];
      if (VER_NEGO_EN)
      begin
        auto_nxt = req.wdata[VER_AUTO];
        filt_nxt = req.wdata[VER_FILT];
      end
    end
    if (stat.hf_strobe)
    begin
      if (!filt_r)
      begin
        rxver_nxt = stat.rx_version;
        cand_nxt = stat.rx_version;
        cnt_nxt = FILT_COUNT;
      end
      else if (stat.rx_version != cand_r)
      begin
        cand_nxt = stat.rx_version;
        cnt_nxt = 3'h1;
      end
      else if (cnt_r != FILT_COUNT)
      begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r + 3'h1 == FILT_COUNT)
        begin
          rxver_nxt = cand_r;
        end
      end
    end
    if (auto_r)
    begin
      txver_nxt = seed_zero ? VER_PLAIN : VER_SCRAMBLED;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl_r <= {2'h0, ROLE_AT_BUILD, 1'b0};
      rate_r <= RATE_AT_BUILD;
      auto_r <= VER_NEGO_EN;
      filt_r <= VER_NEGO_EN;
      txver_r <= VER_RESET;
      rxver_r <= 8'h00;
      cand_r <= 8'h00;
      cnt_r <= 3'h0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      rate_r <= rate_nxt;
      auto_r <= auto_nxt;
      filt_r <= filt_nxt;
      txver_r <= txver_nxt;
      rxver_r <= rxver_nxt;
      cand_r <= cand_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read data and link outputs
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (req.rd)
    begin
      unique case (req.addr)
        OFS_CTRL: rdata_nxt[3:0] = ctrl_r;
        OFS_RATE: rdata_nxt[RATE_W-1:0] = rate_r;
        OFS_VER:
        begin
          rdata_nxt[VER_RX_VALID] = rx_valid;
          rdata_nxt[VER_RX_LSB +: 8] = rxver_r;
          rdata_nxt[VER_AUTO] = auto_r;
          rdata_nxt[VER_FILT] = filt_r;
          rdata_nxt[VER_TX_LSB +: 8] = txver_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_nxt_s.tx_enable = ctrl_r[CTRL_TX_EN];
    ctrl_nxt_s.role_slave = ctrl_r[CTRL_ROLE];
    ctrl_nxt_s.self_sync = ctrl_r[CTRL_SELF_SYNC] && ctrl_r[CTRL_ROLE];
    ctrl_nxt_s.ins_en = ctrl_r[CTRL_INS_EN];
    ctrl_nxt_s.line_rate = (stat.nego_rate != '0) ? stat.nego_rate
                                                  : rate_r;
    ctrl_nxt_s.tx_version = txver_r;
    ctrl_nxt_s.scramble = !seed_zero;
    ins_nxt = ctrl_r[CTRL_INS_EN] ? ins_flag : 2'h0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rdata <= 32'h0000_0000;
      ctrl <= '0;
      ins_strobe <= 2'h0;
    end
    else
    begin
      rdata <= rdata_nxt;
      ctrl <= ctrl_nxt_s;
      ins_strobe <= ins_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Check sequences
  // ----------------------------------------------------------------------
  sequence ctrl_write_seq;
    req.wr && req.addr == OFS_CTRL;
  endsequence

  sequence rate_write_seq;
    req.wr && req.addr == OFS_RATE && RATE_NEGO_EN;
  endsequence

  sequence ver_write_seq;
    req.wr && req.addr == OFS_VER && !auto_r;
  endsequence

  sequence plain_frame_seq;
    stat.hf_strobe && !filt_r;
  endsequence

  sequence fifth_frame_seq;
    stat.hf_strobe && filt_r && stat.rx_version == cand_r
      && cnt_r == FILT_COUNT - 3'h1;
  endsequence

  sequence unmapped_read_seq;
    req.rd && req.addr != OFS_CTRL && req.addr != OFS_RATE
      && req.addr != OFS_VER;
  endsequence

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  insert_gate_a:
    assert property (!ctrl_r[CTRL_INS_EN] |=> ins_strobe == 2'h0)
    else $error("Insertion without enable.");
  insert_pass_a:
    assert property (ctrl_r[CTRL_INS_EN] |=> ins_strobe == $past(ins_flag))
    else $error("Flagged entry not inserted.");
  self_sync_a:
    assert property (ctrl.self_sync |-> ctrl.role_slave)
    else $error("Self sync outside slave role.");
  role_out_a:
    assert property (!$past(sys_rst)
      |-> ctrl.role_slave == $past(ctrl_r[CTRL_ROLE]))
    else $error("Role output mismatch.");
  ctrl_write_a:
    assert property (ctrl_write_seq |=> ctrl_r == $past(req.wdata[3:0]))
    else $error("Control write lost.");
  tx_gate_a:
    assert property ($past(ctrl_r[CTRL_TX_EN]) != ctrl.tx_enable
      |-> $past(sys_rst))
    else $error("Transmit enable mismatch.");
  rate_field_a:
    assert property (stat.nego_rate == '0
      |=> ctrl.line_rate == $past(rate_r))
    else $error("Rate field not used.");
  rate_read_a:
    assert property (req.rd && req.addr == OFS_RATE
      |=> rdata[RATE_W-1:0] == $past(rate_r))
    else $error("Rate read mismatch.");
  rate_override_a:
    assert property (stat.nego_rate != '0
      |=> ctrl.line_rate == $past(stat.nego_rate))
    else $error("Negotiated rate not used.");
  rate_ro_a:
    assert property (!RATE_NEGO_EN |-> $stable(rate_r))
    else $error("Read-only rate changed.");
  rate_write_a:
    assert property (rate_write_seq
      |=> rate_r == $past(req.wdata[RATE_W-1:0]))
    else $error("Rate write lost.");
  rx_valid_a:
    assert property (req.rd && req.addr == OFS_VER && rx_valid
      |=> rdata[VER_RX_VALID])
    else $error("Version valid flag lost.");
  rx_plain_a:
    assert property (plain_frame_seq
      |=> rxver_r == $past(stat.rx_version))
    else $error("Unfiltered version not taken.");
  rx_ver_read_a:
    assert property (req.rd && req.addr == OFS_VER
      |=> rdata[VER_RX_LSB +: 8] == $past(rxver_r))
    else $error("Received version read mismatch.");
  auto_read_a:
    assert property (req.rd && req.addr == OFS_VER
      |=> rdata[VER_AUTO] == $past(auto_r))
    else $error("Auto bit read mismatch.");
  ver_ro_a:
    assert property (!VER_NEGO_EN |-> !auto_r && !filt_r)
    else $error("Auto bits set without build option.");
  filter_hold_a:
    assert property (filt_r && rxver_r != $past(rxver_r)
      |-> cnt_r == FILT_COUNT)
    else $error("Filtered version taken early.");
  filter_take_a:
    assert property (fifth_frame_seq
      |=> rxver_r == $past(stat.rx_version))
    else $error("Fifth equal version not taken.");
  ver_write_a:
    assert property (ver_write_seq
      |=> txver_r == $past(req.wdata[VER_TX_LSB +: 8]))
    else $error("Version write lost.");
  tx_version_out_a:
    assert property (!$past(sys_rst)
      |-> ctrl.tx_version == $past(txver_r))
    else $error("Transmit version output mismatch.");
  auto_ver_a:
    assert property (auto_r && seed_zero |=> txver_r == VER_PLAIN)
    else $error("Auto version not plain.");
  scramble_out_a:
    assert property (seed_zero |=> !ctrl.scramble)
    else $error("Scrambling with zero seed.");
  reserved_a:
    assert property (req.rd && req.addr == OFS_CTRL
      |=> rdata[31:4] == 28'h0)
    else $error("Reserved bits nonzero.");
  unmapped_read_a:
    assert property (unmapped_read_seq |=> rdata == 32'h0000_0000)
    else $error("Unmapped read not zero.");

endmodule : link_cfg_regs

// [rtl/link_cfg_pkg.sv]
package link_cfg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_RATE = 8'h0C;
  localparam logic [7:0] OFS_VER = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_ROLE = 1;
  localparam int CTRL_SELF_SYNC = 2;
  localparam int CTRL_INS_EN = 3;
  localparam int RATE_W = 5;
  localparam int VER_TX_LSB = 0;
  localparam int VER_FILT = 8;
  localparam int VER_AUTO = 9;
  localparam int VER_RX_LSB = 16;
  localparam int VER_RX_VALID = 24;

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [7:0] VER_PLAIN = 8'h01;
  localparam logic [7:0] VER_SCRAMBLED = 8'h02;
  localparam logic [7:0] VER_RESET = 8'h01;
  localparam logic [2:0] FILT_COUNT = 3'h5;
  localparam logic ROLE_MASTER = 1'b0;
  localparam logic ROLE_SLAVE = 1'b1;
  localparam logic [4:0] RATE_DEFAULT = 5'h01;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic tx_enable;
    logic role_slave;
    logic self_sync;
    logic ins_en;
    logic [RATE_W-1:0] line_rate;
    logic [7:0] tx_version;
    logic scramble;
  } link_ctrl_s;

  typedef struct packed {
    logic hf_strobe;
    logic [7:0] rx_version;
    logic [RATE_W-1:0] nego_rate;
  } link_stat_s;

endpackage : link_cfg_pkg

// [tb/link_far_end.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Far-end hyperframe source
// ----------------------------------------------------------------------
module link_far_end
  import link_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic [link_cfg_pkg::RATE_W-1:0] nego,
  output link_cfg_pkg::link_stat_s stat
);
  initial stat = '{hf_strobe: 1'b0, rx_version: 8'h00, nego_rate: '0};
  always @(posedge core_clk) stat.nego_rate <= nego;
  // Sends n hyperframes; the byte is inverted between frames.
  task automatic send_hf(input logic [7:0] v, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      stat.hf_strobe <= 1'b1;
      stat.rx_version <= v;
      @(posedge core_clk);
      stat.hf_strobe <= 1'b0;
      stat.rx_version <= ~v;
      repeat (2) @(posedge core_clk);
    end
  endtask : send_hf
endmodule : link_far_end

// [tb/cpri_link_config_regs_test.sv]
`timescale 1ns/1ps
module cpri_link_config_regs_test;
  import link_cfg_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } row_s;
  logic core_clk;
  logic sys_rst;
  reg_req_s req;
  logic [31:0] rdata;
  logic seed_zero;
  logic [1:0] ins_flag;
  logic [1:0] ins_strobe;
  logic [RATE_W-1:0] nego;
  link_stat_s stat;
  link_ctrl_s ctrl;
  logic [31:0] got;
  int failures;
  int checks_done;
  row_s rows [5] = '{
    '{OFS_CTRL, 32'hFFFFFFFF, 32'h0000000F},
    '{OFS_RATE, 32'hFFFFFFF0, 32'h00000010},
    '{8'h04, 32'hFFFFFFFF, 32'h00000000},
    '{OFS_VER, 32'hFFFFFD02, 32'h00000101},
    '{OFS_VER, 32'hFFFFFD02, 32'h00000102}
  };

  link_cfg_regs link_cfg_regs_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .req(req), .rdata(rdata), .seed_zero(seed_zero), .stat(stat),
    .ins_flag(ins_flag), .ins_strobe(ins_strobe), .ctrl(ctrl));
  link_far_end link_far_end_inst (.core_clk(core_clk), .nego(nego),
    .stat(stat));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic [31:0] w,
    input logic we);
    @(posedge core_clk);
    req <= '{addr: a, wdata: w, wr: we, rd: !we};
    @(posedge core_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
    got = rdata;
  endtask : bus

  task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    #50000;
    failures++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    req = '0;
    seed_zero = 1'b1;
    ins_flag = 2'h2;
    nego = '0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(OFS_CTRL, 32'h0, 1'b0);
    chk(got, {30'h0, ROLE_MASTER, 1'b0});
    bus(OFS_RATE, 32'h0, 1'b0);
    chk(got, {27'h0, RATE_DEFAULT});
    bus(OFS_VER, 32'h0, 1'b0);
    chk(got, 32'h00000301);
    foreach (rows[i])
    begin
      bus(rows[i].a, rows[i].w, 1'b1);
      bus(rows[i].a, 32'h0, 1'b0);
      chk(got, rows[i].e);
    end
    settle();
    chk({28'h0, ctrl.tx_enable, ctrl.role_slave, ctrl.self_sync,
      ctrl.ins_en}, 32'hF);
    chk({27'h0, ctrl.line_rate}, 32'h10);
    chk({30'h0, ins_strobe}, 32'h2);
    chk({24'h0, ctrl.tx_version}, 32'h2);
    @(posedge core_clk);
    nego <= 5'h02;
    settle();
    chk({27'h0, ctrl.line_rate}, 32'h02);
    @(posedge core_clk);
    nego <= '0;
    link_far_end_inst.send_hf(8'h02, 4);
    bus(OFS_VER, 32'h0, 1'b0);
    chk(got, 32'h00000102);
    link_far_end_inst.send_hf(8'h02, 1);
    bus(OFS_VER, 32'h0, 1'b0);
    chk(got, 32'h01020102);
    bus(OFS_VER, 32'h1, 1'b1);
    link_far_end_inst.send_hf(8'h07, 1);
    bus(OFS_VER, 32'h0, 1'b0);
    chk(got, 32'h00070001);
    bus(OFS_VER, 32'h200, 1'b1);
    @(posedge core_clk);
    seed_zero <= 1'b0;
    settle();
    chk({24'h0, ctrl.tx_version}, 32'h2);
    chk({31'h0, ctrl.scramble}, 32'h1);
    bus(OFS_VER, 32'h0, 1'b0);
    chk(got, 32'h00070202);
    @(posedge core_clk);
    seed_zero <= 1'b1;
    ins_flag <= 2'h3;
    bus(OFS_CTRL, 32'h0, 1'b1);
    bus(OFS_VER, 32'h0, 1'b0);
    chk(got, 32'h00070201);
    settle();
    chk({31'h0, ctrl.scramble}, 32'h0);
    chk({28'h0, ctrl.tx_enable, ctrl.role_slave, ctrl.self_sync,
      ctrl.ins_en}, 32'h0);
    chk({30'h0, ins_strobe}, 32'h0);
    bus(OFS_CTRL, 32'hF, 1'b1);
    bus(OFS_RATE, 32'h3, 1'b1);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(OFS_CTRL, 32'h0, 1'b0);
    chk(got, {30'h0, ROLE_MASTER, 1'b0});
    bus(OFS_RATE, 32'h0, 1'b0);
    chk(got, {27'h0, RATE_DEFAULT});
    bus(OFS_VER, 32'h0, 1'b0);
    chk(got, 32'h00000301);
    give_verdict();
  end
endmodule : cpri_link_config_regs_test
